// ===== hw/gpio_mux_pkg.sv
// constants for the general purpose pin block with alternate functions
package gpio_mux_pkg;
    localparam int PIN_COUNT = 9;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    // pin slots: slot 8 is pin 11
    localparam int SLOT_RST_B = 0;
    localparam int SLOT_RST_C = 1;
    localparam int SLOT_IRQ_A = 2;
    localparam int SLOT_IRQ_C = 4;
    localparam int SLOT_EVENT = 7;
    localparam int SLOT_RST_D = 8;
    localparam logic [8:0] ALT_CAPABLE = 9'h197;
    localparam logic [8:0] ALT_IS_OUT = 9'h183;
    // register offsets
    localparam logic [3:0] OFS_OUT_DATA = 4'h0;
    localparam logic [3:0] OFS_DIR = 4'h1;
    localparam logic [3:0] OFS_ALT_SEL = 4'h2;
    localparam logic [3:0] OFS_PIN_IN = 4'h3;
    localparam logic [3:0] OFS_IRQ_STAT = 4'h4;
    localparam logic [3:0] OFS_IRQ_MASK = 4'h5;
    localparam logic [3:0] OFS_FUNC_CTL = 4'h6;
    localparam logic [3:0] OFS_FUNC_STAT = 4'h7;
    // reset values
    localparam logic [8:0] OUT_DATA_RST = 9'h000;
    localparam logic [8:0] DIR_RST = 9'h000;
    localparam logic [8:0] ALT_SEL_RST = 9'h000;
    localparam logic [2:0] IRQ_MASK_RST = 3'h0;
    // func_ctl bits: port resets b,c,d asserted, event deasserted
    localparam int FC_RST_B = 0;
    localparam int FC_RST_C = 1;
    localparam int FC_RST_D = 2;
    localparam int FC_EVENT = 3;
    localparam logic [3:0] FUNC_CTL_RST = 4'h7;
    // irq status bits
    localparam int IS_EXP = 0;
    localparam int IS_PIN_A = 1;
    localparam int IS_PIN_C = 2;
endpackage

// ===== hw/gpio_alternate_function_mux.sv
// general purpose pins with port reset, expander interrupt and event functions
// Overview of operation
// R1 - names ending low mean asserted at zero
// R2 - other signals are asserted when high
// R3 - nine bit pins: 0 to 7 and 11
// R4 - pin 0 alternate drives port b reset
// R5 - pin 1 alternate drives port c reset
// R6 - pin 11 alternate drives port d reset
// R7 - pin 2 alternate takes expander interrupt a
// R8 - pin 4 alternate takes expander interrupt c
// R9 - pin 7 alternate drives system event low
// R10 - port 0 upstream; downstream ports 2,4,6
// R11 - software picks each pin direction
// R12 - alternates set by software, management bus, eeprom
// R13 - expander interrupt requests hot-plug input read
// R14 - alternate function overrides software direction
// R15 - pins 3,5,6 offer plain bit only
`timescale 1ns/10ps
module gpio_alternate_function_mux (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // register port
    input wire logic [gpio_mux_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [gpio_mux_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [gpio_mux_pkg::DATA_W-1:0] reg_rdata,
    // alternate enables loaded by management bus or eeprom
    input wire logic cfg_alt_load,
    input wire logic [gpio_mux_pkg::PIN_COUNT-1:0] cfg_alt_sel,
    // switch-side functions
    input wire logic port_b_reset,
    input wire logic port_c_reset,
    input wire logic port_d_reset,
    input wire logic system_event,
    input wire logic hp_read_done,
    output logic hp_read_req,
    output logic irq,
    // pins; slot 8 is pin 11
    input wire logic [gpio_mux_pkg::PIN_COUNT-1:0] pin_in,
    output logic [gpio_mux_pkg::PIN_COUNT-1:0] pin_out,
    output logic [gpio_mux_pkg::PIN_COUNT-1:0] pin_oe_n
);
    typedef struct packed {
        logic [8:0] out_data;
        logic [8:0] dir;
        logic [8:0] alt_sel;
        logic [8:0] pin_in_q;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic [3:0] func_ctl;
        logic hp_req;
        logic [8:0] pin_out;
        logic [8:0] pin_oe_n;
        logic [31:0] rdata;
        logic irq;
    } state_t;

    state_t st_reg;
    state_t st_next;
    logic rst_n;
    // kept out of the state struct: it is reset by the raw pin, the struct by its copy
    logic [1:0] rst_sync_reg;

    // release of async reset through two flops
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // zero-extend a nine-bit field to the bus width
    function automatic logic [31:0] ext9(input logic [8:0] v);
        ext9 = {23'h000000, v};
    endfunction

    logic [8:0] alt_drive;
    logic [8:0] eff_alt;
    logic irq_a_edge;
    logic irq_c_edge;

    always_comb begin
        eff_alt = st_reg.alt_sel & gpio_mux_pkg::ALT_CAPABLE; // R15
        alt_drive = 9'h000;
        alt_drive[gpio_mux_pkg::SLOT_RST_B] = ~port_b_reset; // R4 R10 R1
        alt_drive[gpio_mux_pkg::SLOT_RST_C] = ~port_c_reset; // R5 R10 R1
        alt_drive[gpio_mux_pkg::SLOT_RST_D] = ~port_d_reset; // R6 R10 R1
        alt_drive[gpio_mux_pkg::SLOT_EVENT] = ~system_event; // R9 R1
        // falling edge on expander line, alternate-selected pins only
        irq_a_edge = eff_alt[gpio_mux_pkg::SLOT_IRQ_A]
            & ~pin_in[gpio_mux_pkg::SLOT_IRQ_A]
            & st_reg.pin_in_q[gpio_mux_pkg::SLOT_IRQ_A]; // R7 R1
        irq_c_edge = eff_alt[gpio_mux_pkg::SLOT_IRQ_C]
            & ~pin_in[gpio_mux_pkg::SLOT_IRQ_C]
            & st_reg.pin_in_q[gpio_mux_pkg::SLOT_IRQ_C]; // R8 R1
    end

    always_comb begin
        st_next = st_reg;
        st_next.pin_in_q = pin_in;
        if (reg_wr) begin
            case (reg_addr)
                gpio_mux_pkg::OFS_OUT_DATA: st_next.out_data = reg_wdata[8:0]; // R3
                gpio_mux_pkg::OFS_DIR: st_next.dir = reg_wdata[8:0]; // R11
                gpio_mux_pkg::OFS_ALT_SEL: st_next.alt_sel = reg_wdata[8:0]; // R12
                gpio_mux_pkg::OFS_IRQ_STAT: st_next.irq_stat = st_reg.irq_stat & ~reg_wdata[2:0];
                gpio_mux_pkg::OFS_IRQ_MASK: st_next.irq_mask = reg_wdata[2:0];
                gpio_mux_pkg::OFS_FUNC_CTL: st_next.func_ctl = reg_wdata[3:0];
                default: st_next.alt_sel = st_next.alt_sel;
            endcase
        end
        // management bus or eeprom load wins over a same-cycle software write
        if (cfg_alt_load) begin
            st_next.alt_sel = cfg_alt_sel; // R12
        end
        // expander interrupt asks for a read of all hot-plug inputs
        if (irq_a_edge || irq_c_edge) begin
            st_next.hp_req = 1'b1; // R13
        end else if (hp_read_done) begin
            st_next.hp_req = 1'b0;
        end
        // set beats write-one-to-clear
        if (irq_a_edge || irq_c_edge) begin
            st_next.irq_stat[gpio_mux_pkg::IS_EXP] = 1'b1;
        end
        if (irq_a_edge) begin
            st_next.irq_stat[gpio_mux_pkg::IS_PIN_A] = 1'b1;
        end
        if (irq_c_edge) begin
            st_next.irq_stat[gpio_mux_pkg::IS_PIN_C] = 1'b1;
        end
        st_next.irq = |(st_next.irq_stat & st_next.irq_mask);
        // pin drive: alternate overrides software direction
        for (int i = 0; i < gpio_mux_pkg::PIN_COUNT; i++) begin
            if (eff_alt[i]) begin
                st_next.pin_oe_n[i] = ~gpio_mux_pkg::ALT_IS_OUT[i]; // R14
                st_next.pin_out[i] = gpio_mux_pkg::ALT_IS_OUT[i] & alt_drive[i];
            end else begin
                st_next.pin_oe_n[i] = ~st_reg.dir[i]; // R11 R3 R2
                st_next.pin_out[i] = st_reg.out_data[i];
            end
        end
        st_next.rdata = 32'h00000000;
        if (reg_rd) begin
            case (reg_addr)
                gpio_mux_pkg::OFS_OUT_DATA: st_next.rdata = ext9(st_reg.out_data);
                gpio_mux_pkg::OFS_DIR: st_next.rdata = ext9(st_reg.dir);
                gpio_mux_pkg::OFS_ALT_SEL: st_next.rdata = ext9(eff_alt);
                gpio_mux_pkg::OFS_PIN_IN: st_next.rdata = ext9(st_reg.pin_in_q);
                gpio_mux_pkg::OFS_IRQ_STAT: st_next.rdata = {29'h0, st_reg.irq_stat};
                gpio_mux_pkg::OFS_IRQ_MASK: st_next.rdata = {29'h0, st_reg.irq_mask};
                gpio_mux_pkg::OFS_FUNC_CTL: st_next.rdata = {28'h0, st_reg.func_ctl};
                gpio_mux_pkg::OFS_FUNC_STAT: st_next.rdata = {31'h0, st_reg.hp_req};
                default: st_next.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg.out_data <= gpio_mux_pkg::OUT_DATA_RST;
            st_reg.dir <= gpio_mux_pkg::DIR_RST;
            st_reg.alt_sel <= gpio_mux_pkg::ALT_SEL_RST;
            st_reg.pin_in_q <= 9'h1ff;
            st_reg.irq_stat <= 3'h0;
            st_reg.irq_mask <= gpio_mux_pkg::IRQ_MASK_RST;
            st_reg.func_ctl <= gpio_mux_pkg::FUNC_CTL_RST;
            st_reg.hp_req <= 1'b0;
            st_reg.pin_out <= 9'h000;
            st_reg.pin_oe_n <= 9'h1ff;
            st_reg.rdata <= 32'h00000000;
            st_reg.irq <= 1'b0;
        end else begin
            st_reg.out_data <= st_next.out_data;
            st_reg.dir <= st_next.dir;
            st_reg.alt_sel <= st_next.alt_sel;
            st_reg.pin_in_q <= st_next.pin_in_q;
            st_reg.irq_stat <= st_next.irq_stat;
            st_reg.irq_mask <= st_next.irq_mask;
            st_reg.func_ctl <= st_next.func_ctl;
            st_reg.hp_req <= st_next.hp_req;
            st_reg.pin_out <= st_next.pin_out;
            st_reg.pin_oe_n <= st_next.pin_oe_n;
            st_reg.rdata <= st_next.rdata;
            st_reg.irq <= st_next.irq;
        end
    end

    assign reg_rdata = st_reg.rdata;
    assign hp_read_req = st_reg.hp_req;
    assign irq = st_reg.irq;
    assign pin_out = st_reg.pin_out;
    assign pin_oe_n = st_reg.pin_oe_n;

    // assertions
    a_alt_dir_override: assert property (@(posedge ref_clk) disable iff (!rst_n)
        st_reg.alt_sel[gpio_mux_pkg::SLOT_IRQ_A] |=> pin_oe_n[gpio_mux_pkg::SLOT_IRQ_A]) // R14
        else $error("expander pin a driven while alternate selected");
    a_rst_b_drive: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_reg.alt_sel[0] && port_b_reset) |=> (!pin_out[0] && !pin_oe_n[0])) // R4
        else $error("port b reset not driven low");
    a_rst_c_drive: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_reg.alt_sel[1] && !port_c_reset) |=> (pin_out[1] && !pin_oe_n[1])) // R5
        else $error("port c reset not released high");
    a_rst_d_drive: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_reg.alt_sel[8] && port_d_reset) |=> !pin_out[8]) // R6
        else $error("port d reset not driven low");
    a_event_drive: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_reg.alt_sel[7] && system_event) |=> (!pin_out[7] && !pin_oe_n[7])) // R9
        else $error("event pin not low");
    a_irq_a_req: assert property (@(posedge ref_clk) disable iff (!rst_n)
        irq_a_edge |=> (hp_read_req && st_reg.irq_stat[gpio_mux_pkg::IS_PIN_A])) // R7
        else $error("expander a edge lost");
    a_irq_c_req: assert property (@(posedge ref_clk) disable iff (!rst_n)
        irq_c_edge |=> (hp_read_req && st_reg.irq_stat[gpio_mux_pkg::IS_PIN_C])) // R8
        else $error("expander c edge lost");
    a_hp_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (hp_read_req && !hp_read_done) |=> hp_read_req) // R13
        else $error("hot-plug read request dropped early");
    a_plain_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!st_reg.dir[3]) |=> pin_oe_n[3]) // R15
        else $error("plain pin 3 driven as output");
    a_dir_soft: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!st_reg.alt_sel[5] && st_reg.dir[5]) |=> (!pin_oe_n[5] && pin_out[5] == $past(st_reg.out_data[5]))) // R11
        else $error("software direction ignored");

    // status, interrupt, alternate select and read data bookkeeping
    a_irq_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
        1'b1
        |-> (irq == |(st_reg.irq_stat & st_reg.irq_mask))) // R2
        else $error("interrupt level disagrees with status and mask");

    a_stat_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !reg_wr
        |=> ((st_reg.irq_stat & $past(st_reg.irq_stat)) == $past(st_reg.irq_stat))) // R7
        else $error("status bit lost without a clear");

    a_hp_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (hp_read_done && !irq_a_edge && !irq_c_edge)
        |=> !hp_read_req) // R13
        else $error("hot-plug read request not cleared");

    a_cfg_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cfg_alt_load
        |=> (st_reg.alt_sel == $past(cfg_alt_sel))) // R12
        else $error("loaded alternate select not taken");

    a_alt_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == gpio_mux_pkg::OFS_ALT_SEL)
        |=> (reg_rdata[8:0] == ($past(st_reg.alt_sel) & gpio_mux_pkg::ALT_CAPABLE))) // R15
        else $error("alternate select read shows incapable pins");

    a_func_stat_rd: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == gpio_mux_pkg::OFS_FUNC_STAT)
        |=> (reg_rdata == {31'h0, $past(hp_read_req)})) // R13
        else $error("function status read wrong");

    a_rdata_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !reg_rd
        |=> (reg_rdata == 32'h00000000)) // R3
        else $error("read data not zero outside a read");

    // pin direction and drive
    a_irq_c_dir: assert property (@(posedge ref_clk) disable iff (!rst_n)
        st_reg.alt_sel[gpio_mux_pkg::SLOT_IRQ_C]
        |=> pin_oe_n[gpio_mux_pkg::SLOT_IRQ_C]) // R14
        else $error("expander pin c driven while alternate selected");

    a_rst_d_dir: assert property (@(posedge ref_clk) disable iff (!rst_n)
        st_reg.alt_sel[gpio_mux_pkg::SLOT_RST_D]
        |=> !pin_oe_n[gpio_mux_pkg::SLOT_RST_D]) // R6
        else $error("port d reset pin not driven");

    a_rst_b_release: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_reg.alt_sel[0] && !port_b_reset)
        |=> pin_out[0]) // R4
        else $error("port b reset not released high");

    a_rst_c_assert: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_reg.alt_sel[1] && port_c_reset)
        |=> (!pin_out[1] && !pin_oe_n[1])) // R5
        else $error("port c reset not driven low");

    a_event_release: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_reg.alt_sel[7] && !system_event)
        |=> (pin_out[7] && !pin_oe_n[7])) // R9
        else $error("event pin not released high");

    a_plain_six: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_reg.alt_sel[6] && st_reg.dir[6])
        |=> !pin_oe_n[6]) // R15
        else $error("plain pin 6 taken by alternate select");

    c_irq_seen: cover property (@(posedge ref_clk) disable iff (!rst_n) irq_a_edge ##1 irq);
    c_port_reset: cover property (@(posedge ref_clk) disable iff (!rst_n)
        st_reg.alt_sel[0] && port_b_reset);
    c_hp_done: cover property (@(posedge ref_clk) disable iff (!rst_n) hp_read_req ##1 !hp_read_req);
    c_irq_c_edge: cover property (@(posedge ref_clk) disable iff (!rst_n)
        irq_c_edge ##1 hp_read_req);
endmodule // gpio_alternate_function_mux

// ===== verification/pin_partner.sv
// board model: open-drain expander interrupt lines with pull-ups, plain board levels
`timescale 1ns/10ps
module pin_partner (
    // device side
    input wire logic [8:0] pin_out,
    input wire logic [8:0] pin_oe_n,
    // expander and board stimulus
    input wire logic exp_a_low,
    input wire logic exp_c_low,
    input wire logic [8:0] board_val,
    // resolved pin levels
    output logic [8:0] pin_in
);
    logic [8:0] pull;
    always_comb begin
        pull = board_val;
        pull[gpio_mux_pkg::SLOT_IRQ_A] = exp_a_low;
        pull[gpio_mux_pkg::SLOT_IRQ_C] = exp_c_low;
        for (int k = 0; k < 9; k++) begin
            pin_in[k] = pin_oe_n[k] ? pull[k] : pin_out[k];
        end
        // open drain: the expander wins even over a driving pin
        pin_in[gpio_mux_pkg::SLOT_IRQ_A] = pin_in[gpio_mux_pkg::SLOT_IRQ_A] & exp_a_low;
        pin_in[gpio_mux_pkg::SLOT_IRQ_C] = pin_in[gpio_mux_pkg::SLOT_IRQ_C] & exp_c_low;
    end
endmodule // pin_partner

// ===== verification/tb_top.sv
// testbench for the pin block with alternate functions
`timescale 1ns/10ps
module tb_top;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic cfg_alt_load = 1'b0;
    logic [8:0] cfg_alt_sel = 9'h000;
    logic [3:0] src = 4'h0; // port b,c,d resets, event
    logic hp_read_done = 1'b0;
    logic exp_a_low = 1'b1;
    logic exp_c_low = 1'b1;
    logic [8:0] board_val = 9'h000;
    logic [31:0] reg_rdata;
    logic hp_read_req, irq;
    logic [8:0] pin_in, pin_out, pin_oe_n;
    int miscompares = 0;
    int cmp_count = 0;
    int seed = 30192;
    int out_m, dir_m, alt_m, mask_m, stat_m, i, k;
    always #25 ref_clk = ~ref_clk;
    gpio_alternate_function_mux dut (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cfg_alt_load(cfg_alt_load), .cfg_alt_sel(cfg_alt_sel), .port_b_reset(src[0]),
        .port_c_reset(src[1]), .port_d_reset(src[2]), .system_event(src[3]),
        .hp_read_done(hp_read_done), .hp_read_req(hp_read_req), .irq(irq),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
    pin_partner board (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .exp_a_low(exp_a_low),
        .exp_c_low(exp_c_low), .board_val(board_val), .pin_in(pin_in));
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string name);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(name, exp, reg_rdata);
    endtask
    task automatic chk_pins;
        logic [8:0] oe, ov, alt_src;
        alt_src = {~src[2], ~src[3], 5'h00, ~src[1], ~src[0]};
        for (k = 0; k < 9; k++) begin
            if (gpio_mux_pkg::ALT_CAPABLE[k] && alt_m[k]) begin
                oe[k] = !gpio_mux_pkg::ALT_IS_OUT[k];
                ov[k] = alt_src[k] & gpio_mux_pkg::ALT_IS_OUT[k];
            end else begin
                oe[k] = !dir_m[k];
                ov[k] = out_m[k] & dir_m[k];
            end
        end
        repeat (2) @(posedge ref_clk);
        #1 chk("pin_oe_n", 32'(oe), 32'(pin_oe_n));
        chk("pin_out", 32'(ov), 32'(pin_out & ~pin_oe_n));
    endtask
    task automatic chk_irq(input logic hp);
        repeat (3) @(posedge ref_clk);
        #1 chk("irq", 32'((stat_m & mask_m) != 0), 32'(irq));
        chk("hp_read_req", 32'(hp), 32'(hp_read_req));
        rd(gpio_mux_pkg::OFS_IRQ_STAT, stat_m, "irq_stat");
        rd(gpio_mux_pkg::OFS_FUNC_STAT, 32'(hp), "func_stat");
    endtask
    task automatic fire(input int c);
        @(posedge ref_clk);
        if (c != 0) exp_c_low <= 1'b0;
        else exp_a_low <= 1'b0;
        repeat (3) @(posedge ref_clk);
        exp_a_low <= 1'b1;
        exp_c_low <= 1'b1;
    endtask
    task automatic done_pulse;
        @(posedge ref_clk);
        hp_read_done <= 1'b1;
        @(posedge ref_clk);
        hp_read_done <= 1'b0;
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge ref_clk);
        miscompares++;
        print_verdict();
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        #1 chk("pin_oe_n", 32'h1ff, 32'(pin_oe_n));
        @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        for (i = 0; i < 16; i++) begin
            if (i != 3) rd(4'(i), (i == 6) ? 32'h7 : 32'h0, "reset_value");
        end
        wr(4'h9, 32'h1ff);
        rd(4'h9, 32'h0, "unmapped");
        wr(gpio_mux_pkg::OFS_FUNC_CTL, 32'h5);
        rd(gpio_mux_pkg::OFS_FUNC_CTL, 32'h5, "func_ctl");
        for (i = 0; i < 24; i++) begin
            out_m = $random(seed) & 'h1ff;
            dir_m = $random(seed) & 'h1ff;
            alt_m = $random(seed) & 'h1ff;
            @(posedge ref_clk);
            board_val <= 9'($random(seed));
            src <= 4'($random(seed));
            wr(gpio_mux_pkg::OFS_OUT_DATA, out_m);
            wr(gpio_mux_pkg::OFS_DIR, dir_m);
            if (i[0]) begin
                wr(gpio_mux_pkg::OFS_ALT_SEL, alt_m);
            end else begin
                @(posedge ref_clk);
                cfg_alt_load <= 1'b1;
                cfg_alt_sel <= 9'(alt_m);
                @(posedge ref_clk);
                cfg_alt_load <= 1'b0;
            end
            chk_pins();
            rd(gpio_mux_pkg::OFS_ALT_SEL, alt_m & 'h197, "alt_sel");
            rd(gpio_mux_pkg::OFS_PIN_IN, 32'(pin_in), "pin_in");
        end
        stat_m = 0;
        mask_m = 0;
        wr(gpio_mux_pkg::OFS_DIR, 32'h0);
        wr(gpio_mux_pkg::OFS_ALT_SEL, 32'h0);
        fire(0);
        chk_irq(1'b0);
        wr(gpio_mux_pkg::OFS_ALT_SEL, 32'h014);
        fire(0);
        stat_m = 3;
        chk_irq(1'b1);
        done_pulse();
        mask_m = 2;
        wr(gpio_mux_pkg::OFS_IRQ_MASK, mask_m);
        chk_irq(1'b0);
        wr(gpio_mux_pkg::OFS_IRQ_STAT, 32'h2);
        stat_m = 1;
        chk_irq(1'b0);
        fire(1);
        stat_m = 5;
        chk_irq(1'b1);
        mask_m = 4;
        wr(gpio_mux_pkg::OFS_IRQ_MASK, mask_m);
        wr(gpio_mux_pkg::OFS_IRQ_STAT, 32'h1);
        stat_m = 4;
        chk_irq(1'b1);
        wr(gpio_mux_pkg::OFS_IRQ_STAT, 32'h7);
        stat_m = 0;
        done_pulse();
        chk_irq(1'b0);
        print_verdict();
    end
endmodule // tb_top
